// >>> hdl/smdr_pkg.sv
// Shared constants and types for the service message and digest report block
package smdr_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0]  ADDR_CMD          = 4'h0;
  localparam logic [3:0]  ADDR_STATUS       = 4'h4;
  localparam logic [3:0]  ADDR_RESP         = 4'h8;
  localparam logic [3:0]  ADDR_FLAGS        = 4'hC;

  // Message codes
  localparam logic [7:0]  STATUS_UNRECOGNIZED = 8'hFC;
  localparam logic [7:0]  CMD_POR_DIGEST_ERR  = 8'hF1;

  // Service codes that are answered by the service engines
  localparam logic [7:0]  CMD_DEV_CERT      = 8'h00;
  localparam logic [7:0]  CMD_SERIAL        = 8'h01;
  localparam logic [7:0]  CMD_USERCODE      = 8'h04;
  localparam logic [7:0]  CMD_DESIGN_VER    = 8'h05;
  localparam logic [7:0]  CMD_IAP           = 8'h14;
  localparam logic [7:0]  CMD_ISP           = 8'h15;
  localparam logic [7:0]  CMD_NVM_CHECK     = 8'h17;

  // Field positions of digest_fail_flags
  localparam int          FLAG_FABRIC_BIT   = 0;
  localparam int          FLAG_ARRAY0_BIT   = 1;
  localparam int          FLAG_ARRAY1_BIT   = 2;
  localparam int          NUM_CHECKS        = 3;

  // Field positions of the status register
  localparam int          STAT_BOOT_BIT     = 0;
  localparam int          STAT_CHECK_BIT    = 1;
  localparam int          STAT_TX_BUSY_BIT  = 2;
  localparam int          STAT_RESP_BIT     = 3;
  localparam int          STAT_POR_BIT      = 4;

  // Field positions of the flags register
  localparam int          FREG_SEL_LSB      = 8;
  localparam int          FREG_EN_BIT       = 16;

  // Reset values and timing
  localparam logic [7:0]  FLAGS_RST         = 8'h00;
  localparam int          SETTLE_CYC        = 8;

  typedef enum logic [4:0] {
    ST_SETTLE = 5'h01,
    ST_START  = 5'h02,
    ST_WAIT   = 5'h04,
    ST_REPORT = 5'h08,
    ST_RUN    = 5'h10
  } smdr_state_t;

  function automatic logic is_supported(input logic [7:0] code);
    case (code)
      CMD_DEV_CERT, CMD_SERIAL, CMD_USERCODE, CMD_DESIGN_VER,
      CMD_IAP, CMD_ISP, CMD_NVM_CHECK: is_supported = 1'b1;
      default:                         is_supported = 1'b0;
    endcase
  endfunction

endpackage

// >>> hdl/smdr_msg_if.sv
// Carrier between the message source and the two-byte serializer
`timescale 1ns/1ps
interface smdr_msg_if;
  logic       req;
  logic [7:0] byte0;
  logic [7:0] byte1;
  logic       busy;
  logic       tx_valid;
  logic       tx_first;
  logic [7:0] tx_byte;

  modport src (output req, byte0, byte1, input busy, tx_valid, tx_first, tx_byte);
  modport snk (input req, byte0, byte1, output busy, tx_valid, tx_first, tx_byte);
endinterface

// >>> hdl/smdr_msg_tx.sv
// Two-byte message serializer toward the fabric, no reply expected
`timescale 1ns/1ps
module smdr_msg_tx (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Message carrier
  smdr_msg_if.snk  msg
);

  logic       busy_q;
  logic [7:0] hold_q;
  logic       valid_q;
  logic       first_q;
  logic [7:0] byte_q;

  assign msg.busy     = busy_q;
  assign msg.tx_valid = valid_q;
  assign msg.tx_first = first_q;
  assign msg.tx_byte  = byte_q;

  // Fire and forget: the second byte always follows the first
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      busy_q  <= 1'b0;
      hold_q  <= 8'h00;
      valid_q <= 1'b0;
      first_q <= 1'b0;
      byte_q  <= 8'h00;
    end else if (busy_q) begin
      busy_q  <= 1'b0;
      valid_q <= 1'b1;
      first_q <= 1'b0;
      byte_q  <= hold_q;
    end else if (msg.req) begin
      busy_q  <= 1'b1;
      hold_q  <= msg.byte1;
      valid_q <= 1'b1;
      first_q <= 1'b1;
      byte_q  <= msg.byte0;
    end else begin
      valid_q <= 1'b0;
      first_q <= 1'b0;
    end
  end

  property p_two_bytes;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (valid_q && first_q) |=> (valid_q && !first_q && byte_q == $past(hold_q));
  endproperty
  a_two_bytes: assert property (p_two_bytes) else $error("second byte did not follow");

endmodule // smdr_msg_tx

// >>> hdl/smdr_top.sv
// Service response and start-up digest report logic with Avalon-MM registers
// Function
// - Flag bit 1 reports first flash array digest mismatch.
// - Flag bit 0 reports fabric configuration digest mismatch.
// - Flag bit 2 reports second flash array mismatch; bits 7 to 3 read zero.
// - Unsupported command answers two bytes: the command, then status 252.
// - Asynchronous messages go out on events without waiting for any reply.
// - Enabled start-up check compares selected digests and raises an error message on a mismatch.
// - Start-up error message is code 241 then the digest flag byte.
// - A mismatch never stops boot; boot completes and message is sent.
// - Start-up check runs only when the programmed enable flag is set.
`timescale 1ns/1ps
module smdr_top #(
  parameter int SETTLE_CYC = smdr_pkg::SETTLE_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Programmed straps
  input  wire logic        por_check_en_i,
  input  wire logic [2:0]  por_select_i,
  // Digest engine
  output logic             dig_start_o,
  output logic      [2:0]  dig_select_o,
  input  wire logic        dig_done_i,
  input  wire logic [2:0]  dig_mismatch_i,
  // Boot and command forwarding
  output logic             boot_done_o,
  output logic             cmd_fwd_valid_o,
  output logic      [7:0]  cmd_fwd_byte_o,
  // Message stream to fabric
  output logic             tx_valid_o,
  output logic             tx_first_o,
  output logic      [7:0]  tx_byte_o
);

  // Straps reach strap_q on the fourth edge, so the decision must come later
  if (SETTLE_CYC < 5 || SETTLE_CYC > 255) begin : g_bad_settle
    $error("SETTLE_CYC must outlast the strap synchroniser, 5 to 255");
  end

  localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);
  smdr_pkg::smdr_state_t state_q;
  logic [7:0]  settle_q;
  logic [3:0]  sync1_q;
  logic [3:0]  sync2_q;
  logic [3:0]  sync3_q;
  logic [3:0]  strap_q;
  logic        chk_en_q;
  logic [2:0]  sel_q;
  logic [7:0]  flags_q;
  logic        por_pend_q;
  logic        resp_pend_q;
  logic [7:0]  resp_b0_q;
  logic [7:0]  resp_b1_q;
  logic        req_q;
  logic [7:0]  req_b0_q;
  logic [7:0]  req_b1_q;
  logic        waitreq_q;
  logic [31:0] rdata_q;
  logic        dig_start_q;
  logic        boot_q;
  logic        fwd_valid_q;
  logic [7:0]  fwd_byte_q;

  smdr_msg_if msg ();
  smdr_msg_tx u_tx (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .msg       (msg)
  );

  assign msg.req   = req_q;
  assign msg.byte0 = req_b0_q;
  assign msg.byte1 = req_b1_q;

  // Avalon-MM handshake: one wait state, longer for command writes while a response is pending
  wire logic       bus_req   = avs_read_i || avs_write_i;
  wire logic       cmd_stall = avs_write_i && (avs_address_i == smdr_pkg::ADDR_CMD) && resp_pend_q;
  wire logic       wr_done   = avs_write_i && !waitreq_q;
  wire logic       cmd_wr    = wr_done && (avs_address_i == smdr_pkg::ADDR_CMD) && avs_byteenable_i[0];
  wire logic [7:0] cmd_byte  = avs_writedata_i[7:0];
  wire logic       unsup_wr  = cmd_wr && !smdr_pkg::is_supported(cmd_byte);

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      waitreq_q <= 1'b1;
    end else begin
      waitreq_q <= !(bus_req && waitreq_q && !cmd_stall);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_req && waitreq_q && !cmd_stall) begin
      case (avs_address_i)
        smdr_pkg::ADDR_STATUS: begin
          rdata_q                             <= 32'h0000_0000;
          rdata_q[smdr_pkg::STAT_BOOT_BIT]    <= boot_q;
          rdata_q[smdr_pkg::STAT_CHECK_BIT]   <= (state_q != smdr_pkg::ST_RUN);
          rdata_q[smdr_pkg::STAT_TX_BUSY_BIT] <= msg.busy || req_q;
          rdata_q[smdr_pkg::STAT_RESP_BIT]    <= resp_pend_q;
          rdata_q[smdr_pkg::STAT_POR_BIT]     <= por_pend_q;
        end
        smdr_pkg::ADDR_RESP: rdata_q <= {16'h0000, resp_b1_q, resp_b0_q};
        smdr_pkg::ADDR_FLAGS: begin
          rdata_q                                      <= {24'h00_0000, flags_q};
          rdata_q[smdr_pkg::FREG_SEL_LSB +: 3]         <= sel_q;
          rdata_q[smdr_pkg::FREG_EN_BIT]               <= chk_en_q;
        end
        default:             rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Straps come from the programmed array: three flops, accepted once stable
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      sync3_q <= 4'h0;
      strap_q <= 4'h0;
    end else begin
      sync1_q <= {por_check_en_i, por_select_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        strap_q <= sync3_q;
      end
    end
  end

  // Start-up sequence
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state_q  <= smdr_pkg::ST_SETTLE;
      settle_q <= 8'h00;
      chk_en_q <= 1'b0;
      sel_q    <= 3'h0;
    end else begin
      case (state_q)
        smdr_pkg::ST_SETTLE: begin
          settle_q <= settle_q + 8'h01;
          if (settle_q == SETTLE_LAST) begin
            chk_en_q <= strap_q[3];
            sel_q    <= strap_q[2:0];
            // Check only when programmed on and something is selected
            if (strap_q[3] && (strap_q[2:0] != 3'h0)) begin
              state_q <= smdr_pkg::ST_START;
            end else begin
              state_q <= smdr_pkg::ST_RUN;
            end
          end
        end
        smdr_pkg::ST_START:  state_q <= smdr_pkg::ST_WAIT;
        smdr_pkg::ST_WAIT: begin
          if (dig_done_i) begin
            state_q <= smdr_pkg::ST_REPORT;
          end
        end
        smdr_pkg::ST_REPORT: state_q <= smdr_pkg::ST_RUN;
        smdr_pkg::ST_RUN:    state_q <= smdr_pkg::ST_RUN;
        default:             state_q <= smdr_pkg::ST_SETTLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      dig_start_q <= 1'b0;
    end else begin
      dig_start_q <= (state_q == smdr_pkg::ST_START);
    end
  end

  // Only selected checks can flag; reserved bits stay zero
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      flags_q <= smdr_pkg::FLAGS_RST;
    end else if (state_q == smdr_pkg::ST_WAIT && dig_done_i) begin
      flags_q                            <= smdr_pkg::FLAGS_RST;
      flags_q[smdr_pkg::FLAG_FABRIC_BIT] <= dig_mismatch_i[0] && sel_q[0];
      flags_q[smdr_pkg::FLAG_ARRAY0_BIT] <= dig_mismatch_i[1] && sel_q[1];
      flags_q[smdr_pkg::FLAG_ARRAY1_BIT] <= dig_mismatch_i[2] && sel_q[2];
    end
  end

  // Boot proceeds whether or not a mismatch was found
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      boot_q <= 1'b0;
    end else if (state_q == smdr_pkg::ST_REPORT || (state_q == smdr_pkg::ST_RUN)) begin
      boot_q <= 1'b1;
    end
  end

  // Supported codes go on to the service engines, others are answered here
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      fwd_valid_q <= 1'b0;
      fwd_byte_q  <= 8'h00;
    end else begin
      fwd_valid_q <= cmd_wr && smdr_pkg::is_supported(cmd_byte);
      if (cmd_wr) begin
        fwd_byte_q <= cmd_byte;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      resp_b0_q <= 8'h00;
      resp_b1_q <= 8'h00;
    end else if (unsup_wr) begin
      resp_b0_q <= cmd_byte;
      resp_b1_q <= smdr_pkg::STATUS_UNRECOGNIZED;
    end
  end

  // Pending messages; the start-up report wins the serializer first
  wire logic launch = !msg.busy && !req_q && (por_pend_q || resp_pend_q);

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      por_pend_q <= 1'b0;
    end else if (state_q == smdr_pkg::ST_REPORT && (flags_q != smdr_pkg::FLAGS_RST)) begin
      por_pend_q <= 1'b1;
    end else if (launch) begin
      por_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      resp_pend_q <= 1'b0;
    end else if (unsup_wr) begin
      resp_pend_q <= 1'b1;
    end else if (launch && !por_pend_q) begin
      resp_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      req_q    <= 1'b0;
      req_b0_q <= 8'h00;
      req_b1_q <= 8'h00;
    end else begin
      req_q <= launch;
      if (launch && por_pend_q) begin
        req_b0_q <= smdr_pkg::CMD_POR_DIGEST_ERR;
        req_b1_q <= flags_q;
      end else if (launch) begin
        req_b0_q <= resp_b0_q;
        req_b1_q <= resp_b1_q;
      end
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = waitreq_q;
  assign dig_start_o       = dig_start_q;
  assign dig_select_o      = sel_q;
  assign boot_done_o       = boot_q;
  assign cmd_fwd_valid_o   = fwd_valid_q;
  assign cmd_fwd_byte_o    = fwd_byte_q;
  assign tx_valid_o        = msg.tx_valid;
  assign tx_first_o        = msg.tx_first;
  assign tx_byte_o         = msg.tx_byte;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  wire logic done_in_wait = (state_q == smdr_pkg::ST_WAIT) && dig_done_i;

  property p_flag_array0;
    done_in_wait |=> flags_q[1] == ($past(dig_mismatch_i[1]) && sel_q[1]);
  endproperty
  a_flag_array0: assert property (p_flag_array0) else $error("array0 flag wrong");
  property p_flag_fabric;
    done_in_wait |=> flags_q[0] == ($past(dig_mismatch_i[0]) && sel_q[0]);
  endproperty
  a_flag_fabric: assert property (p_flag_fabric) else $error("fabric flag wrong");
  property p_flag_array1;
    done_in_wait |=> flags_q[2] == ($past(dig_mismatch_i[2]) && sel_q[2]) && flags_q[7:3] == 5'h00;
  endproperty
  a_flag_array1: assert property (p_flag_array1) else $error("array1 or reserved flag wrong");
  property p_unsup_resp;
    unsup_wr |=> resp_pend_q && resp_b1_q == smdr_pkg::STATUS_UNRECOGNIZED && resp_b0_q == $past(cmd_byte);
  endproperty
  a_unsup_resp: assert property (p_unsup_resp) else $error("unrecognized response not formed");
  property p_resp_on_wire;
    (tx_valid_o && tx_first_o && tx_byte_o != smdr_pkg::CMD_POR_DIGEST_ERR) |=>
      tx_valid_o && tx_byte_o == smdr_pkg::STATUS_UNRECOGNIZED;
  endproperty
  a_resp_on_wire: assert property (p_resp_on_wire) else $error("status byte not 252");
  property p_no_reply_wait;
    (req_q && !msg.busy) |=> tx_valid_o && tx_first_o ##1 tx_valid_o && !tx_first_o;
  endproperty
  a_no_reply_wait: assert property (p_no_reply_wait) else $error("message stalled");
  property p_start_sel;
    dig_start_o |-> state_q == smdr_pkg::ST_WAIT && dig_select_o != 3'h0 && chk_en_q;
  endproperty
  a_start_sel: assert property (p_start_sel) else $error("digest start without enable");
  property p_report_raise;
    (state_q == smdr_pkg::ST_REPORT && flags_q != 8'h00) |=> por_pend_q || req_q;
  endproperty
  a_report_raise: assert property (p_report_raise) else $error("mismatch not reported");
  // Keyed on the source: a rejected command of value 241 also starts with that byte
  property p_por_msg;
    (launch && por_pend_q) |=> ##1 tx_valid_o && tx_first_o && tx_byte_o == smdr_pkg::CMD_POR_DIGEST_ERR
      ##1 tx_valid_o && !tx_first_o && tx_byte_o == flags_q && flags_q != 8'h00;
  endproperty
  a_por_msg: assert property (p_por_msg) else $error("digest message body wrong");
  property p_boot_anyway;
    done_in_wait |-> ##2 boot_done_o;
  endproperty
  a_boot_anyway: assert property (p_boot_anyway) else $error("boot held by check");
  property p_silent_pass;
    (state_q == smdr_pkg::ST_REPORT && flags_q == 8'h00 && !por_pend_q) |=> !por_pend_q;
  endproperty
  a_silent_pass: assert property (p_silent_pass) else $error("message on clean check");
  c_unsup:   cover property (unsup_wr);
  c_por_msg: cover property (tx_first_o && tx_byte_o == smdr_pkg::CMD_POR_DIGEST_ERR);
  c_no_chk:  cover property (boot_done_o && !chk_en_q);
  c_fwd:     cover property (cmd_fwd_valid_o);

endmodule // smdr_top

// >>> tb/smdr_far_model.sv
// Far-side model: digest engine and fabric message receiver
`timescale 1ns/1ps
module smdr_far_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  // Digest engine side
  input  wire logic       dig_start_i,
  input  wire logic [2:0] mism_cfg_i,
  input  wire logic [7:0] delay_cfg_i,
  output logic            dig_done_o,
  output logic      [2:0] dig_mismatch_o,
  // Message stream from the block
  input  wire logic       tx_valid_i,
  input  wire logic       tx_first_i,
  input  wire logic [7:0] tx_byte_i
);
  logic [15:0] msgs[$];
  int          frame_err;
  logic [7:0]  cnt_q;
  logic        busy_q;
  logic        first_q;
  logic [7:0]  b0_q;

  initial frame_err = 0;

  // Mismatch lines only hold meaning with done; inverted garbage otherwise
  assign dig_mismatch_o = dig_done_o ? mism_cfg_i : ~mism_cfg_i;

  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cnt_q      <= 8'h00;
      busy_q     <= 1'b0;
      dig_done_o <= 1'b0;
    end else begin
      dig_done_o <= 1'b0;
      if (dig_start_i) begin
        busy_q <= 1'b1;
        cnt_q  <= delay_cfg_i;
      end else if (busy_q) begin
        if (cnt_q == 8'h00) begin
          busy_q     <= 1'b0;
          dig_done_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end

  // Consumes messages and never answers; a real receiver may drop them
  always @(posedge ref_clk_i) begin
    if (rstn_i) begin
      first_q <= tx_valid_i && tx_first_i;
      if (tx_valid_i && tx_first_i) b0_q <= tx_byte_i;
      if (tx_valid_i && !tx_first_i) begin
        if (!first_q) frame_err++;
        msgs.push_back({b0_q, tx_byte_i});
      end else if (first_q) begin
        frame_err++;
      end
    end
  end
endmodule // smdr_far_model

// >>> tb/tb.sv
// Self-checking bench for the service message and digest report block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin fails++; $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb;
  typedef struct {logic en; logic [2:0] sel; logic [2:0] mis; logic [7:0] dly; logic [7:0] flg;} smdr_row_t;
  logic        clk, rstn, rd, wr, en, boot, fwdv, txv, txf, wreq, dstart, ddone;
  logic [3:0]  addr, be;
  logic [31:0] wdata, rdata, q;
  logic [2:0]  sel, mis, dsel, dmis;
  logic [7:0]  dly, fwdb, txb, ef, fwd_last;
  int          fails, checks_done, fwd_n, k;
  smdr_row_t   rows[7];
  logic [7:0]  bad_codes[3];
  logic [7:0]  good_codes[7];

  smdr_top #(.SETTLE_CYC(5)) DUT (
    .ref_clk_i(clk), .rstn_i(rstn), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .por_check_en_i(en), .por_select_i(sel), .dig_start_o(dstart), .dig_select_o(dsel),
    .dig_done_i(ddone), .dig_mismatch_i(dmis), .boot_done_o(boot), .cmd_fwd_valid_o(fwdv),
    .cmd_fwd_byte_o(fwdb), .tx_valid_o(txv), .tx_first_o(txf), .tx_byte_o(txb));

  smdr_far_model FAR (
    .ref_clk_i(clk), .rstn_i(rstn), .dig_start_i(dstart), .mism_cfg_i(mis), .delay_cfg_i(dly),
    .dig_done_o(ddone), .dig_mismatch_o(dmis), .tx_valid_i(txv), .tx_first_i(txf), .tx_byte_i(txb));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  always @(posedge clk) begin
    if (fwdv === 1'b1) begin
      fwd_n++;
      fwd_last = fwdb;
    end
  end

  task automatic conclude;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 300);
    if (n >= 300) begin
      fails++;
      $display("BAD waitrequest exp 0 got %b", wreq);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Polls status until no message is pending or on the wire
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, smdr_pkg::ADDR_STATUS, 32'h0, 4'hF);
      n++;
    end while (q[4:2] !== 3'b000 && n < 50);
    repeat (2) @(posedge clk);
  endtask

  task automatic restart(input smdr_row_t r);
    int n;
    @(posedge clk);
    rstn <= 1'b0;
    en <= r.en;
    sel <= r.sel;
    mis <= r.mis;
    dly <= r.dly;
    repeat (20) @(posedge clk);
    FAR.msgs.delete();
    rstn <= 1'b1;
    n = 0;
    while (boot !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    wait_idle();
  endtask

  initial begin
    fails = 0;
    checks_done = 0;
    fwd_n = 0;
    rstn = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    be = 4'hF;
    en = 1'b0;
    sel = 3'h0;
    mis = 3'h0;
    dly = 8'h00;
    rows = '{'{1'b0, 3'h7, 3'h7, 8'h01, 8'h00}, '{1'b1, 3'h7, 3'h0, 8'h01, 8'h00},
             '{1'b1, 3'h7, 3'h1, 8'h01, 8'h01}, '{1'b1, 3'h7, 3'h2, 8'h3C, 8'h02},
             '{1'b1, 3'h7, 3'h4, 8'h00, 8'h04}, '{1'b1, 3'h3, 3'h7, 8'h05, 8'h03},
             '{1'b1, 3'h0, 3'h7, 8'h01, 8'h00}};
    bad_codes = '{8'h02, 8'hF1, 8'hFF};
    good_codes = '{smdr_pkg::CMD_DEV_CERT, smdr_pkg::CMD_SERIAL, smdr_pkg::CMD_USERCODE,
                   smdr_pkg::CMD_DESIGN_VER, smdr_pkg::CMD_IAP, smdr_pkg::CMD_ISP, smdr_pkg::CMD_NVM_CHECK};
    foreach (rows[i]) begin
      restart(rows[i]);
      ef = rows[i].flg;
      `CHK("boot_done", 1'b1, boot)
      if (rows[i].en && rows[i].sel != 3'h0) `CHK("dig_select", rows[i].sel, dsel)
      `CHK("msg_count", (ef != 8'h00) ? 1 : 0, FAR.msgs.size())
      if (ef != 8'h00) `CHK("por_msg", {8'hF1, ef}, FAR.msgs[0])
      bus(1'b0, smdr_pkg::ADDR_FLAGS, 32'h0, 4'hF);
      `CHK("flags_reg", {rows[i].en, ef}, {q[16], q[7:0]})
      $display("test boot row %0d done", i);
    end
    foreach (bad_codes[i]) begin
      FAR.msgs.delete();
      bus(1'b1, smdr_pkg::ADDR_CMD, {24'h0, bad_codes[i]}, 4'hF);
      wait_idle();
      `CHK("msg_count", 1, FAR.msgs.size())
      if (FAR.msgs.size() > 0) `CHK("resp_msg", {bad_codes[i], 8'hFC}, FAR.msgs[0])
      bus(1'b0, smdr_pkg::ADDR_RESP, 32'h0, 4'hF);
      `CHK("resp_reg", {16'h0, 8'hFC, bad_codes[i]}, q)
    end
    $display("test unsupported codes done");
    FAR.msgs.delete();
    foreach (good_codes[i]) begin
      k = fwd_n;
      bus(1'b1, smdr_pkg::ADDR_CMD, {24'h0, good_codes[i]}, 4'hF);
      repeat (3) @(posedge clk);
      `CHK("fwd_pulses", k + 1, fwd_n)
      `CHK("fwd_byte", good_codes[i], fwd_last)
    end
    wait_idle();
    `CHK("msg_count", 0, FAR.msgs.size())
    $display("test supported codes done");
    bus(1'b1, smdr_pkg::ADDR_CMD, 32'h30, 4'hF);
    bus(1'b1, smdr_pkg::ADDR_CMD, 32'h31, 4'hF);
    wait_idle();
    `CHK("msg_count", 2, FAR.msgs.size())
    if (FAR.msgs.size() == 2) begin
      `CHK("first_resp", 16'h30FC, FAR.msgs[0])
      `CHK("second_resp", 16'h31FC, FAR.msgs[1])
    end
    $display("test back to back done");
    FAR.msgs.delete();
    bus(1'b1, smdr_pkg::ADDR_CMD, 32'h40, 4'hE);
    bus(1'b1, smdr_pkg::ADDR_STATUS, 32'h1F, 4'hF);
    wait_idle();
    `CHK("msg_count", 0, FAR.msgs.size())
    bus(1'b0, 4'h2, 32'h0, 4'hF);
    `CHK("unmapped", 32'h0, q)
    bus(1'b0, smdr_pkg::ADDR_STATUS, 32'h0, 4'hF);
    `CHK("status", 32'h1, q)
    `CHK("framing", 0, FAR.frame_err)
    $display("test refused accesses done");
    conclude();
  end

  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    $display("BAD watchdog exp finish got timeout");
    conclude();
  end
endmodule // tb
